/* rtl/otc_pkg.sv */
// Shared constants and command type for the termination control link
package otc_pkg;

  // Commands carried on the link, one per clock
  typedef enum logic [2:0] {
    cmd_nop,
    cmd_write_bl8,
    cmd_write_bc4,
    cmd_refresh,
    cmd_mrs
  } otc_cmd_t;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_PS      = 25000;
  localparam int ASYNC_ON_MIN_PS    = 2000;
  localparam int ASYNC_ON_MAX_PS    = 8500;
  localparam int ASYNC_OFF_MIN_PS   = 2000;
  localparam int ASYNC_OFF_MAX_PS   = 8500;
  localparam int REFRESH_TIME_NS    = 260;
  // Longest times round down, never below one cycle; refresh time rounds up
  localparam int ASYNC_ON_MAX_CYC   = (ASYNC_ON_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                      (ASYNC_ON_MAX_PS / CLK_PERIOD_PS);
  localparam int ASYNC_OFF_MAX_CYC  = (ASYNC_OFF_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                      (ASYNC_OFF_MAX_PS / CLK_PERIOD_PS);
  localparam int REFRESH_CYC        = (REFRESH_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
  localparam logic [2:0] TERM_HOLD_FOUR  = 3'h4;
  localparam logic [2:0] TERM_HOLD_EIGHT = 3'h6;
  localparam logic [5:0] WR_BACK_BC4     = 6'h04;
  localparam logic [5:0] WR_BACK_BL8     = 6'h06;
  localparam logic [4:0] LAT_OFFSET      = 5'h02;
  localparam logic [4:0] CWL_BASE        = 5'h05;
  localparam logic [4:0] CL_BASE         = 5'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register selects and field positions
  localparam logic [1:0] MR_ZERO = 2'h0;
  localparam logic [1:0] MR_ONE  = 2'h1;
  localparam logic [1:0] MR_TWO  = 2'h2;
  localparam int MR0_DLL_FAST_BIT = 12;
  localparam int MR0_CL_LSB       = 4;
  localparam int MR1_NOM_B2       = 9;
  localparam int MR1_NOM_B1       = 6;
  localparam int MR1_NOM_B0       = 2;
  localparam int MR1_AL_LSB       = 3;
  localparam int MR2_WR_LSB       = 9;
  localparam int MR2_CWL_LSB      = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Termination encodings and resistances
  localparam logic [7:0] REF_OHM      = 8'hF0;
  localparam logic [2:0] NOM_OFF      = 3'h0;
  localparam logic [2:0] NOM_DIV4     = 3'h1;
  localparam logic [2:0] NOM_DIV2     = 3'h2;
  localparam logic [2:0] NOM_DIV6     = 3'h3;
  localparam logic [2:0] NOM_DIV12    = 3'h4;
  localparam logic [2:0] NOM_DIV8     = 3'h5;
  localparam logic [2:0] NOM_WR_LIMIT = 3'h3;
  localparam logic [2:0] NOM_RSV_LO   = 3'h6;
  localparam logic [1:0] WR_OFF       = 2'h0;
  localparam logic [1:0] WR_DIV4      = 2'h1;
  localparam logic [1:0] WR_DIV2      = 2'h2;
  localparam logic [1:0] WR_RSV       = 2'h3;
  localparam logic [1:0] AL_CL_LESS1  = 2'h1;
  localparam logic [1:0] AL_CL_LESS2  = 2'h2;

endpackage

/* rtl/otc_link_if.sv */
// Link between the memory controller and the termination logic
`timescale 1ns/1ps
`default_nettype none
interface otc_link_if;
  import otc_pkg::*;
  logic        cke;
  logic        odt;
  otc_cmd_t    cmd;
  logic [1:0]  mr_sel;
  logic [15:0] mr_data;

  // Memory side only listens
  modport dev (input cke, input odt, input cmd, input mr_sel, input mr_data);
  // Controller drives every line
  modport ctl (output cke, output odt, output cmd, output mr_sel, output mr_data);
endinterface
`default_nettype wire

/* rtl/otc_controller.sv */
// Controller end: drives clock enable, termination pin and commands
`timescale 1ns/1ps
`default_nettype none
module otc_controller
  import otc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  otc_link_if.ctl          link,
  input  wire logic        want_term,
  input  wire logic        wr_req,
  input  wire logic        wr_bc4,
  input  wire logic        ref_req,
  input  wire logic        pd_req,
  input  wire logic        mrs_req,
  input  wire logic [1:0]  mrs_sel,
  input  wire logic [15:0] mrs_data,
  output logic             cmd_done,
  output logic             cmd_refused
);

  logic        cke;
  logic        odt;
  otc_cmd_t    cmd;
  logic [1:0]  mr_sel;
  logic [15:0] mr_data;
  logic [2:0]  hold;
  logic        next_cke;
  logic        next_odt;
  otc_cmd_t    next_cmd;
  logic [1:0]  next_mr_sel;
  logic [15:0] next_mr_data;
  logic [2:0]  next_hold;
  logic        next_done;
  logic        next_refused;
  logic [2:0]  req_nom;
  logic [1:0]  req_wr;
  logic        mrs_bad;

  assign link.cke     = cke;
  assign link.odt     = odt;
  assign link.cmd     = cmd;
  assign link.mr_sel  = mr_sel;
  assign link.mr_data = mr_data;

  // Encodings a mode write would program
  assign req_nom = {mrs_data[MR1_NOM_B2], mrs_data[MR1_NOM_B1], mrs_data[MR1_NOM_B0]};
  assign req_wr  = mrs_data[MR2_WR_LSB +: 2];
  // Reserved codes, and nominal values unusable during writes, never go out
  assign mrs_bad = (mrs_sel == MR_ONE && req_nom > NOM_WR_LIMIT) ||
                   (mrs_sel == MR_TWO && req_wr == WR_RSV);

  ////////////////////////////////////////////////////////////////////////////
  // Command issue, pin hold and power-down; one command per clock that a request is held
  always_comb begin
    next_cke     = !pd_req;
    next_cmd     = cmd_nop;
    next_mr_sel  = mr_sel;
    next_mr_data = mr_data;
    next_done    = 1'b0;
    next_refused = 1'b0;
    next_hold    = (hold != 3'h0) ? hold - 3'h1 : 3'h0;
    next_odt     = odt;
    // Pin may only drop once every hold window has run out
    if (want_term && !odt) begin
      next_odt  = 1'b1;
      next_hold = TERM_HOLD_FOUR - 3'h1;
    end else if (!want_term && odt && hold == 3'h0) begin
      next_odt = 1'b0;
    end
    // Address and command receivers may be off while clock enable is low
    if (!cke && (mrs_req || ref_req || wr_req)) begin
      next_refused = 1'b1;
    end else if (mrs_req) begin
      if (mrs_bad) begin
        next_refused = 1'b1;
      end else begin
        next_cmd     = cmd_mrs;
        next_mr_sel  = mrs_sel;
        next_mr_data = mrs_data;
        next_done    = 1'b1;
      end
    end else if (ref_req) begin
      next_cmd  = cmd_refresh;
      next_done = 1'b1;
    end else if (wr_req) begin
      next_cmd  = wr_bc4 ? cmd_write_bc4 : cmd_write_bl8;
      next_done = 1'b1;
      // Write registered with the pin high restarts the hold, also when
      // the pin rises in the very cycle of the write
      if (next_odt) begin
        if (wr_bc4) begin
          if (next_hold < TERM_HOLD_FOUR - 3'h1) begin
            next_hold = TERM_HOLD_FOUR - 3'h1;
          end
        end else begin
          next_hold = TERM_HOLD_EIGHT - 3'h1;
        end
      end
    end
    if (next_cmd != cmd_nop) begin
      next_cke = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cke         <= 1'b1;
      odt         <= 1'b0;
      cmd         <= cmd_nop;
      mr_sel      <= MR_ZERO;
      mr_data     <= 16'h0000;
      hold        <= 3'h0;
      cmd_done    <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      cke         <= next_cke;
      odt         <= next_odt;
      cmd         <= next_cmd;
      mr_sel      <= next_mr_sel;
      mr_data     <= next_mr_data;
      hold        <= next_hold;
      cmd_done    <= next_done;
      cmd_refused <= next_refused;
    end
  end

endmodule
`default_nettype wire

/* rtl/otc_device.sv */
// Memory end: on-die termination strength, latency and power-down modes
`timescale 1ns/1ps
`default_nettype none
module otc_device
  import otc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  otc_link_if.dev          link,
  output logic             term_on,
  output logic [7:0]       term_ohm,
  output logic             term_write_sel,
  output logic             term_async,
  output logic             term_illegal,
  output logic [4:0]       term_latency
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode register state
  logic        dll_fast;
  logic [2:0]  cl_code;
  logic [1:0]  al_code;
  logic [2:0]  cwl_code;
  logic [2:0]  nom_code;
  logic [1:0]  wr_code;
  logic        next_dll_fast;
  logic [2:0]  next_cl_code;
  logic [1:0]  next_al_code;
  logic [2:0]  next_cwl_code;
  logic [2:0]  next_nom_code;
  logic [1:0]  next_wr_code;
  logic        cmd_live;

  // Commands count only while clock enable is registered high
  assign cmd_live = link.cke;

  // Mode register writes land in their fields
  always_comb begin
    next_dll_fast = dll_fast;
    next_cl_code  = cl_code;
    next_al_code  = al_code;
    next_cwl_code = cwl_code;
    next_nom_code = nom_code;
    next_wr_code  = wr_code;
    if (cmd_live && link.cmd == cmd_mrs) begin
      if (link.mr_sel == MR_ZERO) begin
        next_dll_fast = link.mr_data[MR0_DLL_FAST_BIT];
        next_cl_code  = link.mr_data[MR0_CL_LSB +: 3];
      end else if (link.mr_sel == MR_ONE) begin
        next_nom_code = {link.mr_data[MR1_NOM_B2], link.mr_data[MR1_NOM_B1],
                         link.mr_data[MR1_NOM_B0]};
        next_al_code  = link.mr_data[MR1_AL_LSB +: 2];
      end else if (link.mr_sel == MR_TWO) begin
        next_wr_code  = link.mr_data[MR2_WR_LSB +: 2];
        next_cwl_code = link.mr_data[MR2_CWL_LSB +: 3];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dll_fast <= 1'b0;
      cl_code  <= 3'h1;
      al_code  <= 2'h0;
      cwl_code <= 3'h0;
      nom_code <= NOM_OFF;
      wr_code  <= WR_OFF;
    end else begin
      dll_fast <= next_dll_fast;
      cl_code  <= next_cl_code;
      al_code  <= next_al_code;
      cwl_code <= next_cwl_code;
      nom_code <= next_nom_code;
      wr_code  <= next_wr_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency arithmetic
  logic [4:0]  cas_lat;
  logic [4:0]  add_lat;
  logic [4:0]  odt_lat;
  logic [5:0]  wr_back;

  assign cas_lat = CL_BASE + {2'h0, cl_code};
  always_comb begin
    if (al_code == AL_CL_LESS1) begin
      add_lat = cas_lat - 5'h01;
    end else if (al_code == AL_CL_LESS2) begin
      add_lat = cas_lat - 5'h02;
    end else begin
      add_lat = 5'h00;
    end
  end
  // Same figure for turn-on, turn-off and strength switch
  assign odt_lat = CWL_BASE + {2'h0, cwl_code} + add_lat - LAT_OFFSET;

  ////////////////////////////////////////////////////////////////////////////
  // Pin history, one bit per registered clock
  logic [31:0] odt_hist;
  logic [31:0] next_odt_hist;

  // The pin receiver stays live in power-down, so history never stops
  assign next_odt_hist = {odt_hist[30:0], link.odt};

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      odt_hist <= 32'h0000_0000;
    end else begin
      odt_hist <= next_odt_hist;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down mode tracking and refresh in progress
  logic [7:0]  ref_cnt;
  logic        async_mode;
  logic [7:0]  next_ref_cnt;
  logic        next_async_mode;

  always_comb begin
    next_ref_cnt    = (ref_cnt != 8'h00) ? ref_cnt - 8'h01 : 8'h00;
    next_async_mode = async_mode;
    if (cmd_live && link.cmd == cmd_refresh) begin
      next_ref_cnt = 8'(REFRESH_CYC);
    end
    // Either mode is allowed ahead of entry; sync is kept until the
    // end of the window, which keeps the pipeline output continuous
    if (link.cke) begin
      next_async_mode = 1'b0;
    end else if (!dll_fast && next_ref_cnt == 8'h00) begin
      // Window closes at first low clock enable or after the refresh
      next_async_mode = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ref_cnt    <= 8'h00;
      async_mode <= 1'b0;
    end else begin
      ref_cnt    <= next_ref_cnt;
      async_mode <= next_async_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dynamic termination: write strength window after each write
  logic [5:0]  wr_cnt;
  logic [5:0]  wr_end;
  logic [5:0]  next_wr_cnt;
  logic [5:0]  next_wr_end;
  logic        dyn_on;
  logic        is_write;

  assign dyn_on   = (wr_code != WR_OFF);
  assign is_write = link.cmd == cmd_write_bl8 || link.cmd == cmd_write_bc4;
  assign wr_back  = (link.cmd == cmd_write_bc4) ? WR_BACK_BC4 : WR_BACK_BL8;

  always_comb begin
    next_wr_end = wr_end;
    if (wr_cnt == 6'h00 || wr_cnt >= wr_end) begin
      next_wr_cnt = 6'h00;
    end else begin
      next_wr_cnt = wr_cnt + 6'h01;
    end
    // Later write restarts the window
    if (cmd_live && is_write && dyn_on) begin
      next_wr_cnt = 6'h01;
      next_wr_end = {1'b0, odt_lat} + wr_back;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_cnt <= 6'h00;
      wr_end <= 6'h00;
    end else begin
      wr_cnt <= next_wr_cnt;
      wr_end <= next_wr_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination outputs
  logic        next_on;
  logic        next_sel;
  logic [7:0]  nom_ohm;
  logic [7:0]  wr_ohm;
  logic [7:0]  next_ohm;

  // Strength lookup from the reference resistance
  always_comb begin
    case (nom_code)
      NOM_DIV4:  nom_ohm = REF_OHM / 8'h04;
      NOM_DIV2:  nom_ohm = REF_OHM / 8'h02;
      NOM_DIV6:  nom_ohm = REF_OHM / 8'h06;
      NOM_DIV12: nom_ohm = REF_OHM / 8'h0C;
      NOM_DIV8:  nom_ohm = REF_OHM / 8'h08;
      default:   nom_ohm = 8'h00;
    endcase
    case (wr_code)
      WR_DIV4: wr_ohm = REF_OHM / 8'h04;
      WR_DIV2: wr_ohm = REF_OHM / 8'h02;
      default: wr_ohm = 8'h00;
    endcase
  end

  always_comb begin
    // Async path: pin seen one cycle ago, no additive latency; 2 to 8.5 ns
    // rounds to one clock either way
    if (async_mode) begin
      next_on = term_on ? odt_hist[ASYNC_OFF_MAX_CYC - 1]
                        : odt_hist[ASYNC_ON_MAX_CYC - 1];
    end else if (odt_lat == 5'h00) begin
      next_on = link.odt;
    end else begin
      // Sync path stays inside the merged bounds during the transition
      next_on = odt_hist[odt_lat - 5'h01];
    end
    next_sel = dyn_on && wr_cnt >= {1'b0, odt_lat} && wr_cnt < wr_end;
    if (!next_on) begin
      next_ohm = 8'h00;
    end else if (next_sel) begin
      next_ohm = wr_ohm;
    end else begin
      next_ohm = nom_ohm;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      term_on        <= 1'b0;
      term_ohm       <= 8'h00;
      term_write_sel <= 1'b0;
      term_async     <= 1'b0;
      term_illegal   <= 1'b0;
      term_latency   <= 5'h00;
    end else begin
      term_on        <= next_on;
      term_ohm       <= next_ohm;
      term_write_sel <= next_sel;
      term_async     <= async_mode;
      term_illegal   <= nom_code >= NOM_RSV_LO || wr_code == WR_RSV;
      term_latency   <= odt_lat;
    end
  end

endmodule
`default_nettype wire

/* tb/otc_link_chk.sv */
// Checker for the controller behaviour seen on the termination link
`timescale 1ns/1ps
`default_nettype none
module otc_link_chk
  import otc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        cke,
  input wire logic        odt,
  input var  otc_cmd_t    cmd,
  input wire logic [1:0]  mr_sel,
  input wire logic [15:0] mr_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Hold steps of the pin and the mode write event
  sequence held_four;
    odt [*4];
  endsequence
  sequence held_six;
    odt [*6];
  endsequence
  sequence mode_write(sel);
    cmd == cmd_mrs && mr_sel == sel;
  endsequence

  // Scattered nominal bits gathered into one code
  logic [2:0] nom_code;
  assign nom_code = {mr_data[MR1_NOM_B2], mr_data[MR1_NOM_B1], mr_data[MR1_NOM_B0]};

  ////////////////////////////////////////////////////////////////////////////
  chk_raise_hold: assert property ($rose(odt) |-> held_four)
    else $error("pin dropped early after raise");
  chk_bc4_hold: assert property ((cmd == cmd_write_bc4 && odt) |-> held_four)
    else $error("pin dropped early after short write");
  chk_bl8_hold: assert property ((cmd == cmd_write_bl8 && odt) |-> held_six)
    else $error("pin dropped early after full write");
  // Receivers may be off, so nothing may follow a low clock enable
  chk_pd_quiet: assert property (!cke |=> cmd == cmd_nop)
    else $error("command sent in power-down");
  chk_cmd_cke: assert property (cmd != cmd_nop |-> cke)
    else $error("command with clock enable low");
  chk_nom_write: assert property (mode_write(MR_ONE) |-> nom_code <= NOM_WR_LIMIT)
    else $error("nominal strength not usable in writes");
  chk_nom_reserved: assert property (mode_write(MR_ONE) |-> nom_code < NOM_RSV_LO)
    else $error("reserved nominal code sent");
  chk_wr_reserved: assert property (mode_write(MR_TWO) |-> mr_data[10:9] != WR_RSV)
    else $error("reserved write code sent");
endmodule
`default_nettype wire

/* tb/odt_termination_control_tb.sv */
// Testbench joining controller and device across the termination link
`timescale 1ns/1ps
`default_nettype none
module odt_termination_control_tb;
  import otc_pkg::*;
  logic        sys_clk, resetn, want_term, wr_req, wr_bc4, ref_req, pd_req, mrs_req;
  logic        cmd_done, cmd_refused, term_on, term_write_sel, term_async, term_illegal;
  logic [1:0]  mrs_sel;
  logic [15:0] mrs_data;
  logic [7:0]  term_ohm, ohm_w, exp_ohm;
  logic [4:0]  term_latency;
  logic [2:0]  c;
  logic        odt_q = 1'b0, on_q = 1'b0, sel_q = 1'b0, as_q = 1'b0;
  int          mismatches, compares, cyc, cmd_at, odt_at, on_at, sel_on, sel_off, as_at, fl;

  otc_link_if otc_link_if_i ();
  otc_controller otc_controller_i (.sys_clk(sys_clk), .resetn(resetn), .link(otc_link_if_i),
    .want_term(want_term), .wr_req(wr_req), .wr_bc4(wr_bc4), .ref_req(ref_req),
    .pd_req(pd_req), .mrs_req(mrs_req), .mrs_sel(mrs_sel), .mrs_data(mrs_data),
    .cmd_done(cmd_done), .cmd_refused(cmd_refused));
  otc_device otc_device_i (.sys_clk(sys_clk), .resetn(resetn), .link(otc_link_if_i),
    .term_on(term_on), .term_ohm(term_ohm), .term_write_sel(term_write_sel),
    .term_async(term_async), .term_illegal(term_illegal), .term_latency(term_latency));
  otc_link_chk otc_link_chk_i (.sys_clk(sys_clk), .resetn(resetn),
    .cke(otc_link_if_i.cke), .odt(otc_link_if_i.odt), .cmd(otc_link_if_i.cmd),
    .mr_sel(otc_link_if_i.mr_sel), .mr_data(otc_link_if_i.mr_data));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Event log; device outputs read at an edge were set one edge earlier
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (otc_link_if_i.cmd !== cmd_nop) cmd_at <= cyc;
    if (otc_link_if_i.odt !== odt_q) odt_at <= cyc;
    odt_q <= otc_link_if_i.odt;
    if (term_on !== on_q) on_at <= cyc - 1;
    on_q <= term_on;
    if (term_write_sel === 1'b1 && !sel_q) sel_on <= cyc - 1;
    if (term_write_sel === 1'b0 && sel_q) sel_off <= cyc - 1;
    if (term_write_sel === 1'b1) ohm_w <= term_ohm;
    sel_q <= term_write_sel;
    if (term_async === 1'b1 && !as_q) as_at <= cyc - 1;
    as_q <= term_async;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // One request: k 0 mode write, 1 refresh, 2 full write, 3 short write
  // Dropped after one edge, since a held level would repeat the command
  task automatic req(input int k, input logic [1:0] s, input logic [15:0] d, input int exp);
    @(negedge sys_clk);
    {mrs_req, ref_req, wr_req, wr_bc4} = {k == 0, k == 1, k > 1, k == 3};
    mrs_sel = s;
    mrs_data = d;
    fl = 0;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      if (cmd_done === 1'b1) fl = 1;
      if (cmd_refused === 1'b1) fl = 2;
      @(negedge sys_clk);
      {mrs_req, ref_req, wr_req} = 3'h0;
    end
    chk(fl == exp, "request outcome");
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic close_out;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {resetn, want_term, wr_req, wr_bc4, ref_req, pd_req, mrs_req} = 7'h00;
    mrs_sel = 2'h0;
    mrs_data = 16'h0000;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    idle(1);
    chk(term_latency === 5'h03 && otc_link_if_i.cke === 1'b1, "reset state");
    // Every nominal code, reserved and write-unsafe ones refused
    for (int i = 1; i <= 8; i++) begin
      c = i[2:0];
      req(0, MR_ONE, {6'h00, c[2], 2'h0, c[1], 3'h0, c[0], 2'h0}, c > NOM_WR_LIMIT ? 2 : 1);
      if (i == 1) begin
        want_term = 1'b1;
        idle(8);
        chk(on_at - odt_at == 3, "sync on latency");
      end
      if (c <= NOM_WR_LIMIT) exp_ohm = c == 1 ? REF_OHM / 4 : c == 2 ? REF_OHM / 2 :
                                       c == 3 ? REF_OHM / 6 : 8'h00;
      idle(2);
      chk(term_ohm === exp_ohm, "nominal strength");
    end
    req(0, MR_ONE, 16'h0040, 1);
    want_term = 1'b0;
    idle(8);
    chk(on_at - odt_at == 3 && term_on === 1'b0, "sync off latency");
    // Write codes; pin released early to lean on the hold logic
    for (int j = 1; j <= 3; j++) begin
      req(0, MR_TWO, {5'h00, j[1:0], 9'h000}, j == 3 ? 2 : 1);
      if (j < 3) begin
        want_term = 1'b1;
        idle(6);
        req(j + 1, 2'h0, 16'h0000, 1);
        want_term = 1'b0;
        idle(14);
        chk(sel_on - cmd_at == 3 && sel_off - cmd_at == (j == 1 ? 9 : 7), "write window");
        chk(ohm_w === (j == 1 ? REF_OHM / 4 : REF_OHM / 2), "write strength");
      end
    end
    // Pin raised in the very cycle of a full write must still hold six
    fork
      req(2, 2'h0, 16'h0000, 1);
      begin
        @(negedge sys_clk);
        want_term = 1'b1;
      end
    join
    want_term = 1'b0;
    idle(8);
    chk(odt_at - cmd_at == TERM_HOLD_EIGHT, "hold after raise with write");
    // Power-down with frozen loop and a long additive latency
    req(0, MR_ONE, 16'h000C, 1);
    idle(2);
    chk(term_latency === 5'h07, "latency with additive");
    pd_req = 1'b1;
    idle(4);
    chk(term_async === 1'b1 && otc_link_if_i.cke === 1'b0, "frozen loop mode");
    want_term = 1'b1;
    idle(6);
    chk(on_at - odt_at == 1, "async on");
    want_term = 1'b0;
    idle(6);
    chk(on_at - odt_at == 1 && term_on === 1'b0, "async off");
    req(2, 2'h0, 16'h0000, 2);
    pd_req = 1'b0;
    idle(4);
    chk(term_async === 1'b0, "mode restored");
    // Entry while a refresh is still running
    req(1, 2'h0, 16'h0000, 1);
    pd_req = 1'b1;
    idle(20);
    chk(as_at - cmd_at == REFRESH_CYC + 1, "refresh entry");
    pd_req = 1'b0;
    idle(4);
    // Loop kept running in power-down: stays synchronous
    req(0, MR_ZERO, 16'h1010, 1);
    pd_req = 1'b1;
    idle(8);
    chk(term_async === 1'b0 && otc_link_if_i.cke === 1'b0, "loop kept on");
    pd_req = 1'b0;
    idle(2);
    chk(term_illegal === 1'b0, "reserved code latched");
    close_out;
  end

  // Watchdog, about ten times the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
